// file: hdl/boost_regs_defines.svh
`ifndef BOOST_REGS_DEFINES_SVH
`define BOOST_REGS_DEFINES_SVH

// register offsets on the internal register port
`define BOOST_ISET_ADDR   8'h64
`define BOOST_VSET_ADDR   8'h65
`define BOOST_MASK_ADDR   8'h66

// reset values
`define BOOST_ISET_RST    8'h00
`define BOOST_VSET_RST    8'h00
`define BOOST_MASK_RST    8'h00

// field positions
`define LUT_DIS_BIT       7
`define PEAK_MSB          3
`define VOLT_MSB          5

// sequencing and enable-selection decodes
`define SEQ_PIN_CTRL      3'h7
`define EN_SEL_OFF        2'h0
`define EN_SEL_ON         2'h1
`define EN_SEL_PINS       2'h2

// scale of the two codes
`define PEAK_BASE_MA      9'h064
`define PEAK_STEP_MA      9'h019
`define VOLT_BASE_MV      15'h1388
`define VOLT_STEP_MV      15'h00fa

`endif

// file: hdl/boost_regs_pkg.sv
package boost_regs_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef logic [3:0] peak_code_t;
  typedef logic [5:0] volt_code_t;
endpackage

// file: hdl/pin_sync.sv
`timescale 1ns/1ps
// three-stage synchroniser; a change is accepted once stages two and three
// agree, so a single-cycle glitch that reaches stage two is dropped
module pin_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinLevel
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_pinLevel;

  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync: WIDTH must be at least 1");
  end

  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      next_pinLevel[i] = (stage2[i] == stage3[i]) ? stage3[i] : pinLevel[i];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stage1   <= '0;
      stage2   <= '0;
      stage3   <= '0;
      pinLevel <= '0;
    end else begin
      stage1   <= pinIn;
      stage2   <= stage1;
      stage3   <= stage2;
      pinLevel <= next_pinLevel;
    end
  end
endmodule

// file: hdl/boost_setpoint_pin_enable_regs.sv
// Operation
// RULE1: peak code 3:0, 100mA plus 25mA per step
// RULE2: programmed peak code used only when lookup disabled
// RULE3: voltage code 5:0, 5V plus 250mV per step
// RULE4: software keeps voltage codes at or below 111100
// RULE5: mask bit n selects multipurpose pin n
// RULE6: mask counts only with sequencing 111, selection 10
// RULE7: selected pins combine by logical OR
// RULE8: selection 00 off, 01 on, 10 pins, 11 reserved
// RULE9: lookup table when disable clear, else code
// RULE10: unused bits read zero; fields read back writes
`timescale 1ns/1ps
`include "boost_regs_defines.svh"
module boost_setpoint_pin_enable_regs
  import boost_regs_pkg::*;
#(
  parameter int PINS = 8
) (
  input  wire logic            ref_clk,
  input  wire logic            rst,
  input  wire logic            regWrite,
  input  wire logic            regRead,
  input  wire logic [7:0]      regAddr,
  input  wire logic [7:0]      regWdata,
  output logic      [7:0]      regRdata,
  input  wire logic [2:0]      sequencing_field,
  input  wire logic [1:0]      enable_selection_field,
  input  wire logic            seqEnable,
  input  wire logic [3:0]      lookupCode,
  input  wire logic [PINS-1:0] multipurpose_pin,
  output logic                 boostEnable,
  output logic      [3:0]      effPeakCode,
  output logic      [8:0]      peakCurrentMa,
  output logic      [5:0]      output_voltage_code,
  output logic      [14:0]     outputVoltageMv
);
  if (PINS != 8) begin : g_bad_pins
    $error("boost_setpoint_pin_enable_regs: PINS must be 8");
  end

  reg_byte_t        peakReg;
  reg_byte_t        voltReg;
  reg_byte_t        maskReg;
  logic [PINS-1:0]  pinLevel;

  reg_byte_t        next_peakReg;
  reg_byte_t        next_voltReg;
  reg_byte_t        next_maskReg;
  reg_byte_t        next_regRdata;
  logic             next_boostEnable;
  peak_code_t       next_effPeakCode;
  logic [8:0]       next_peakCurrentMa;
  volt_code_t       next_output_voltage_code;
  logic [14:0]      next_outputVoltageMv;

  pin_sync #(
    .WIDTH (PINS)
  ) u_pin_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .pinIn    (multipurpose_pin),
    .pinLevel (pinLevel)
  );

  // register file: writes land at the edge, reads are answered one cycle on
  always_comb begin
    next_peakReg  = peakReg;
    next_voltReg  = voltReg;
    next_maskReg  = maskReg;
    next_regRdata = 8'h00;
    if (regWrite) begin
      case (regAddr)
        `BOOST_ISET_ADDR: begin
          next_peakReg = {regWdata[`LUT_DIS_BIT], 3'h0,
                          regWdata[`PEAK_MSB:0]}; // RULE10
        end
        `BOOST_VSET_ADDR: begin
          next_voltReg = {2'h0, regWdata[`VOLT_MSB:0]}; // RULE10
        end
        `BOOST_MASK_ADDR: begin
          next_maskReg = regWdata;
        end
        default: begin
          next_maskReg = maskReg;
        end
      endcase
    end
    if (regRead) begin
      case (regAddr)
        `BOOST_ISET_ADDR: next_regRdata = peakReg;
        `BOOST_VSET_ADDR: next_regRdata = voltReg;
        `BOOST_MASK_ADDR: next_regRdata = maskReg;
        default:          next_regRdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      peakReg  <= `BOOST_ISET_RST;
      voltReg  <= `BOOST_VSET_RST;
      maskReg  <= `BOOST_MASK_RST;
      regRdata <= 8'h00;
    end else begin
      peakReg  <= next_peakReg;
      voltReg  <= next_voltReg;
      maskReg  <= next_maskReg;
      regRdata <= next_regRdata;
    end
  end

  // regulator controls; reserved voltage codes pass through untouched,
  // software is trusted to stay within range
  always_comb begin
    next_effPeakCode = peakReg[`LUT_DIS_BIT] ? peakReg[`PEAK_MSB:0]
                                             : lookupCode; // RULE2 RULE9
    next_peakCurrentMa = `PEAK_BASE_MA
                       + `PEAK_STEP_MA * 9'(next_effPeakCode); // RULE1
    next_output_voltage_code = voltReg[`VOLT_MSB:0]; // RULE4
    next_outputVoltageMv = `VOLT_BASE_MV
                         + `VOLT_STEP_MV
                         * 15'(next_output_voltage_code); // RULE3
    if (sequencing_field == `SEQ_PIN_CTRL) begin
      case (enable_selection_field) // RULE8
        `EN_SEL_OFF:  next_boostEnable = 1'b0;
        `EN_SEL_ON:   next_boostEnable = 1'b1;
        `EN_SEL_PINS: next_boostEnable = |(maskReg & pinLevel); // RULE5 RULE7
        default:      next_boostEnable = 1'b0;
      endcase
    end else begin
      // the boot sequencer owns the enable; the mask plays no part
      next_boostEnable = seqEnable; // RULE6
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      boostEnable         <= 1'b0;
      effPeakCode         <= 4'h0;
      peakCurrentMa       <= `PEAK_BASE_MA;
      output_voltage_code <= 6'h00;
      outputVoltageMv     <= `VOLT_BASE_MV;
    end else begin
      boostEnable         <= next_boostEnable;
      effPeakCode         <= next_effPeakCode;
      peakCurrentMa       <= next_peakCurrentMa;
      output_voltage_code <= next_output_voltage_code;
      outputVoltageMv     <= next_outputVoltageMv;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  peak_programmed_a: assert property ( // RULE2
    peakReg[`LUT_DIS_BIT] |=> effPeakCode == $past(peakReg[`PEAK_MSB:0]))
    else $error("programmed peak code not applied");

  peak_lookup_a: assert property ( // RULE9
    !peakReg[`LUT_DIS_BIT] |=> effPeakCode == $past(lookupCode))
    else $error("lookup peak code not applied");

  // current and code are registered at the same edge, so they must agree
  peak_scale_a: assert property ( // RULE1
    peakCurrentMa == `PEAK_BASE_MA + `PEAK_STEP_MA * 9'(effPeakCode))
    else $error("peak current scale wrong");

  // a voltage write takes one edge into the register and one more out
  volt_scale_a: assert property ( // RULE3
    regWrite && regAddr == `BOOST_VSET_ADDR
    |=> ##1 outputVoltageMv == `VOLT_BASE_MV
          + `VOLT_STEP_MV * 15'($past(regWdata[`VOLT_MSB:0], 2)))
    else $error("voltage scale wrong");

  volt_code_a: assert property ( // RULE3
    regWrite && regAddr == `BOOST_VSET_ADDR
    |=> ##1 output_voltage_code == $past(regWdata[`VOLT_MSB:0], 2))
    else $error("voltage code not applied");

  pin_or_a: assert property ( // RULE7
    sequencing_field == `SEQ_PIN_CTRL
    && enable_selection_field == `EN_SEL_PINS
    |=> boostEnable == |($past(maskReg) & $past(pinLevel)))
    else $error("pin enable is not the OR of selected pins");

  sel_decode_a: assert property ( // RULE8
    sequencing_field == `SEQ_PIN_CTRL
    && enable_selection_field != `EN_SEL_PINS
    |=> boostEnable == ($past(enable_selection_field) == `EN_SEL_ON))
    else $error("enable selection decode wrong");

  mask_ignored_a: assert property ( // RULE6
    sequencing_field != `SEQ_PIN_CTRL |=> boostEnable == $past(seqEnable))
    else $error("mask used outside pin control");

  mask_bit_a: assert property ( // RULE5
    sequencing_field == `SEQ_PIN_CTRL
    && enable_selection_field == `EN_SEL_PINS
    && maskReg == 8'h00 |=> !boostEnable)
    else $error("enable without any selected pin");

  unused_zero_a: assert property ( // RULE10
    voltReg[7:6] == 2'h0 && peakReg[6:4] == 3'h0)
    else $error("unused bits not zero");

  readback_a: assert property ( // RULE10
    regWrite && regAddr == `BOOST_VSET_ADDR ##1 regRead
    && regAddr == `BOOST_VSET_ADDR && !regWrite
    |=> regRdata == {2'h0, $past(regWdata[`VOLT_MSB:0], 2)})
    else $error("voltage register readback wrong");

  unmapped_read_a: assert property ( // RULE10
    regRead && regAddr != `BOOST_ISET_ADDR
    && regAddr != `BOOST_VSET_ADDR && regAddr != `BOOST_MASK_ADDR
    |=> regRdata == 8'h00)
    else $error("unmapped read returned data");

  // read data stands one cycle only, so a stale byte is never taken twice
  read_idle_a: assert property ( // RULE10
    !regRead |=> regRdata == 8'h00)
    else $error("read data held without a read");

  pins_on_c: cover property (
    enable_selection_field == `EN_SEL_PINS
    && sequencing_field == `SEQ_PIN_CTRL ##1 boostEnable);
  lut_off_c: cover property (peakReg[`LUT_DIS_BIT] ##1 effPeakCode != 4'h0);
  top_volt_c: cover property (output_voltage_code == 6'h3c);
  seq_own_c: cover property (
    sequencing_field != `SEQ_PIN_CTRL ##1 boostEnable);
  mask_empty_c: cover property (
    enable_selection_field == `EN_SEL_PINS && maskReg == 8'h00);
endmodule

// file: sim/host_model.sv
`timescale 1ns/1ps
// register-port master standing in for the host processor
module host_model
  import boost_regs_pkg::*;
(
  input  wire logic ref_clk,
  output logic      regWrite,
  output logic      regRead,
  output logic [7:0] regAddr,
  output logic [7:0] regWdata,
  input  wire logic [7:0] regRdata
);
  initial begin
    regWrite = 1'b0;
    regRead  = 1'b0;
    regAddr  = 8'h00;
    regWdata = 8'h00;
  end

  // released lines show the inverse so stale values are never reused
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    // callers keep voltage codes at or below 6'h3c
    @(posedge ref_clk);
    #1;
    regWrite = 1'b1;
    regAddr  = a;
    regWdata = d;
    @(posedge ref_clk);
    #1;
    regWrite = 1'b0;
    regAddr  = ~a;
    regWdata = ~d;
  endtask

  // write, then read the same register back at the very next edge
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d,
                       output reg_byte_t q);
    @(posedge ref_clk);
    #1;
    regWrite = 1'b1;
    regAddr  = a;
    regWdata = d;
    @(posedge ref_clk);
    #1;
    regWrite = 1'b0;
    regRead  = 1'b1;
    regWdata = ~d;
    @(posedge ref_clk);
    #1;
    regRead = 1'b0;
    regAddr = ~a;
    q       = regRdata;
  endtask

  task automatic rd(input logic [7:0] a, output reg_byte_t d);
    @(posedge ref_clk);
    #1;
    regRead = 1'b1;
    regAddr = a;
    @(posedge ref_clk);
    #1;
    regRead = 1'b0;
    regAddr = ~a;
    d       = regRdata;
  endtask
endmodule

// file: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import boost_regs_pkg::*;
();
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        regWrite, regRead;
  logic [7:0]  regAddr, regWdata, regRdata;
  logic [2:0]  sequencing_field = 3'h7;
  logic [1:0]  enable_selection_field = 2'h0;
  logic        seqEnable = 1'b0;
  logic [3:0]  lookupCode = 4'h0;
  logic [7:0]  multipurpose_pin = 8'h00;
  logic        boostEnable;
  logic [3:0]  effPeakCode;
  logic [8:0]  peakCurrentMa;
  logic [5:0]  output_voltage_code;
  logic [14:0] outputVoltageMv;
  int          errCount = 0;
  int          checked = 0;

  always #20 ref_clk = ~ref_clk;

  host_model HOST (.ref_clk(ref_clk), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata));

  boost_setpoint_pin_enable_regs #(.PINS(8)) DUT (.ref_clk(ref_clk),
    .rst(rst), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata),
    .sequencing_field(sequencing_field),
    .enable_selection_field(enable_selection_field), .seqEnable(seqEnable),
    .lookupCode(lookupCode), .multipurpose_pin(multipurpose_pin),
    .boostEnable(boostEnable), .effPeakCode(effPeakCode),
    .peakCurrentMa(peakCurrentMa), .output_voltage_code(output_voltage_code),
    .outputVoltageMv(outputVoltageMv));

  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    checked++;
    if (g !== e) begin
      errCount++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic regs_test;
    reg_byte_t d;
    HOST.rd(8'h64, d);
    chk("peak reg reset", 16'h0000, 16'(d));
    HOST.wr(8'h64, 8'hff);
    HOST.rd(8'h64, d);
    chk("peak reg", 16'h008f, 16'(d));
    HOST.wr_rd(8'h65, 8'hfc, d);
    chk("volt reg", 16'h003c, 16'(d));
    HOST.wr(8'h66, 8'ha5);
    HOST.rd(8'h66, d);
    chk("mask reg", 16'h00a5, 16'(d));
    HOST.rd(8'h67, d);
    chk("unmapped", 16'h0000, 16'(d));
  endtask

  task automatic peak_test;
    // lookup disable is set from the previous test, code 4'hf
    lookupCode = 4'h5;
    cyc(2);
    chk("peak code", 16'h000f, 16'(effPeakCode));
    chk("peak ma", 16'h01db, 16'(peakCurrentMa));
    HOST.wr(8'h64, 8'h03);
    cyc(2);
    chk("lut code", 16'h0005, 16'(effPeakCode));
    chk("lut ma", 16'h00e1, 16'(peakCurrentMa));
  endtask

  task automatic volt_test;
    chk("volt top", 16'h4e20, 16'(outputVoltageMv));
    HOST.wr(8'h65, 8'h01);
    cyc(2);
    chk("volt code", 16'h0001, 16'(output_voltage_code));
    chk("volt mv", 16'h1482, 16'(outputVoltageMv));
  endtask

  task automatic pins(logic [7:0] p, logic e);
    multipurpose_pin = p;
    cyc(6);
    chk("pin enable", 16'(e), 16'(boostEnable));
  endtask

  task automatic en_test;
    for (int i = 0; i < 4; i++) begin
      enable_selection_field = 2'(i);
      cyc(2);
      chk("selection", 16'(i == 1), 16'(boostEnable));
    end
    enable_selection_field = 2'h2;
    HOST.wr(8'h66, 8'h04);
    pins(8'h04, 1'b1);
    pins(8'hfb, 1'b0);
    HOST.wr(8'h66, 8'h81);
    pins(8'h80, 1'b1);
    pins(8'h01, 1'b1);
    pins(8'h7e, 1'b0);
    sequencing_field = 3'h3;
    pins(8'h81, 1'b0);
  endtask

  // outside pin control the sequencer owns the enable; then an empty mask
  task automatic seq_test;
    seqEnable = 1'b1;
    cyc(2);
    chk("sequencer enable", 16'h0001, 16'(boostEnable));
    enable_selection_field = 2'h0;
    cyc(2);
    chk("selection ignored", 16'h0001, 16'(boostEnable));
    seqEnable = 1'b0;
    sequencing_field = 3'h7;
    enable_selection_field = 2'h2;
    HOST.wr(8'h66, 8'h00);
    cyc(2);
    chk("empty mask", 16'h0000, 16'(boostEnable));
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", checked, errCount);
    if (errCount == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #(40 * 3000);
    errCount++;
    end_sim();
  end

  initial begin
    cyc(10);
    rst = 1'b0;
    regs_test();
    peak_test();
    volt_test();
    en_test();
    seq_test();
    end_sim();
  end
endmodule
